/* File: verilog/astrf_uart.v */
// asynchronous serial transmit and receive front with an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "astrf_regs.vh"
module astrf_uart (
    // clock and reset
    input wire clk,
    input wire nrst,
    // axi4-lite write address and data
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // serial pins
    input wire receive_pin,
    output wire transmit_pin_out,
    output wire transmit_pin_oe,
    // interrupt request
    output wire serial_irq
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam RX_IDLE = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_DATA = 2'd2;
    localparam RX_STOP = 2'd3;

    reg [7:0] tx_ctrl_reg;
    reg [7:0] rx_ctrl_reg;
    reg [7:0] baud_ctrl_reg;
    reg [7:0] div_lo_reg;
    reg [7:0] div_hi_reg;
    reg [3:0] int_en_reg;
    reg aw_held_reg;
    reg [7:0] aw_addr_reg;
    reg w_held_reg;
    reg [7:0] w_data_reg;
    reg w_lane0_reg;
    reg [8:0] txbuf_reg;
    reg txbuf_full_reg;
    reg [10:0] tsr_reg;
    reg tsr_busy_reg;
    reg [3:0] tx_bits_reg;
    reg [3:0] tx_cnt_reg;
    reg rx_sync1_reg;
    reg rx_sync2_reg;
    reg [1:0] rx_state_reg;
    reg [3:0] rx_cnt_reg;
    reg [1:0] rx_smp_reg;
    reg [8:0] rx_shift_reg;
    reg [3:0] rx_nbit_reg;
    reg oerr_reg;
    reg [9:0] fifo_mem [0:1];
    reg fifo_wp_reg;
    reg fifo_rp_reg;
    reg [1:0] fifo_cnt_reg;
    reg [31:0] rd_mux;
    wire tick16;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function map_ok;
        input [7:0] addr;
        begin
            map_ok = (addr[1:0] == 2'b00) && (addr <= `ASTRF_OFF_INT_CTRL);
        end
    endfunction

    function maj3;
        input a;
        input b;
        input c;
        begin
            maj3 = (a & b) | (a & c) | (b & c);
        end
    endfunction

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    wire port_on = rx_ctrl_reg[`ASTRF_RX_PORT_EN];
    wire async_on = port_on & ~tx_ctrl_reg[`ASTRF_TX_SYNC];
    wire tx_on = async_on & tx_ctrl_reg[`ASTRF_TX_EN];
    wire rx_on = async_on & rx_ctrl_reg[`ASTRF_RX_CONT_EN];
    wire rx_run = rx_on & ~oerr_reg;
    wire tx_flag = tx_on & ~txbuf_full_reg;
    wire rx_flag = (fifo_cnt_reg != 2'd0);
    wire sr_empty = ~tsr_busy_reg;
    wire [9:0] fifo_top = fifo_mem[fifo_rp_reg];
    wire rx_bit = maj3(rx_smp_reg[0], rx_smp_reg[1], rx_sync2_reg);
    wire [8:0] rx_char = rx_ctrl_reg[`ASTRF_RX_NINE] ? rx_shift_reg :
                                                      {1'b0, rx_shift_reg[8:1]};

    // interrupt gated by local, peripheral and global enables
    assign serial_irq = int_en_reg[`ASTRF_INT_GLOBAL_EN] & int_en_reg[`ASTRF_INT_PERIPH_EN] &
                        ((int_en_reg[`ASTRF_INT_TX_EN] & tx_flag) |
                         (int_en_reg[`ASTRF_INT_RX_EN] & rx_flag));

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire wr_en = wr_fire & w_lane0_reg & map_ok(aw_addr_reg);
    wire rd_fire = s_axi_arvalid & ~s_axi_rvalid;
    wire pop = rd_fire & (s_axi_araddr == `ASTRF_OFF_RX_DATA) & rx_flag;
    wire txbuf_wr = wr_en & (aw_addr_reg == `ASTRF_OFF_TX_BUF) & tx_on;

    // read data selection
    always @* begin
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `ASTRF_OFF_TX_CTRL: begin
                rd_mux[7:0] = {tx_ctrl_reg[7:2], sr_empty, tx_ctrl_reg[0]};
            end
            `ASTRF_OFF_RX_CTRL: begin
                rd_mux[7:0] = {rx_ctrl_reg[7:3], rx_flag & fifo_top[9], oerr_reg,
                               rx_flag & fifo_top[8]};
            end
            `ASTRF_OFF_BAUD_CTRL: begin
                rd_mux[7:0] = baud_ctrl_reg;
                rd_mux[`ASTRF_BAUD_RX_IDLE] = (rx_state_reg == RX_IDLE);
            end
            `ASTRF_OFF_DIV_LO: begin
                rd_mux[7:0] = div_lo_reg;
            end
            `ASTRF_OFF_DIV_HI: begin
                rd_mux[7:0] = div_hi_reg;
            end
            `ASTRF_OFF_RX_DATA: begin
                rd_mux[7:0] = fifo_top[7:0];
            end
            `ASTRF_OFF_INT_CTRL: begin
                rd_mux[5:0] = {rx_flag, tx_flag, int_en_reg};
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // channel capture and responses
    always @(posedge clk) begin
        if (!nrst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ASTRF_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `ASTRF_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= map_ok(aw_addr_reg) ? `ASTRF_RESP_OKAY : `ASTRF_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= map_ok(s_axi_araddr) ? `ASTRF_RESP_OKAY : `ASTRF_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // software-written control registers
    always @(posedge clk) begin
        if (!nrst) begin
            tx_ctrl_reg <= `ASTRF_RST_BYTE;
            rx_ctrl_reg <= `ASTRF_RST_BYTE;
            baud_ctrl_reg <= `ASTRF_RST_BYTE;
            div_lo_reg <= `ASTRF_RST_BYTE;
            div_hi_reg <= `ASTRF_RST_BYTE;
            int_en_reg <= 4'h0;
        end else if (wr_en) begin
            case (aw_addr_reg)
                `ASTRF_OFF_TX_CTRL: tx_ctrl_reg <= w_data_reg;
                `ASTRF_OFF_RX_CTRL: rx_ctrl_reg <= w_data_reg;
                `ASTRF_OFF_BAUD_CTRL: baud_ctrl_reg <= w_data_reg;
                `ASTRF_OFF_DIV_LO: div_lo_reg <= w_data_reg;
                `ASTRF_OFF_DIV_HI: div_hi_reg <= w_data_reg;
                `ASTRF_OFF_INT_CTRL: int_en_reg <= w_data_reg[3:0];
                default: int_en_reg <= int_en_reg;
            endcase
        end
    end

    // ----------------------------------------
    // baud generator
    // ----------------------------------------
    astrf_baud_gen u_baud (
        .clk(clk),
        .nrst(nrst),
        .enable(port_on),
        .wide(baud_ctrl_reg[`ASTRF_BAUD_WIDE]),
        .divisor({div_hi_reg, div_lo_reg}),
        .tick16(tick16)
    );

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    assign transmit_pin_out = tsr_reg[0];
    assign transmit_pin_oe = port_on;

    // transmit buffer and shift register
    always @(posedge clk) begin
        if (!nrst || !tx_on) begin
            txbuf_reg <= 9'h000;
            txbuf_full_reg <= 1'b0;
            tsr_reg <= 11'h7FF;
            tsr_busy_reg <= 1'b0;
            tx_bits_reg <= 4'h0;
            tx_cnt_reg <= 4'h0;
        end else begin
            if (txbuf_wr) begin
                // ninth bit latched from control alongside the byte
                txbuf_reg <= {tx_ctrl_reg[`ASTRF_TX_NINTH], w_data_reg};
                txbuf_full_reg <= 1'b1;
            end
            if (!tsr_busy_reg && txbuf_full_reg) begin
                if (!txbuf_wr) begin
                    txbuf_full_reg <= 1'b0;
                end
                tsr_busy_reg <= 1'b1;
                tx_cnt_reg <= 4'h0;
                if (tx_ctrl_reg[`ASTRF_TX_NINE]) begin
                    tsr_reg <= {1'b1, txbuf_reg, 1'b0};
                    tx_bits_reg <= `ASTRF_BITS_9;
                end else begin
                    tsr_reg <= {2'b11, txbuf_reg[7:0], 1'b0};
                    tx_bits_reg <= `ASTRF_BITS_8;
                end
            end else if (tsr_busy_reg && tick16) begin
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
                if (tx_cnt_reg == `ASTRF_OS_LAST) begin
                    tsr_reg <= {1'b1, tsr_reg[10:1]};
                    tx_bits_reg <= tx_bits_reg - 4'h1;
                    if (tx_bits_reg == 4'h1) begin
                        tsr_busy_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    wire rx_keep = ~(rx_ctrl_reg[`ASTRF_RX_ADDR_DET] & rx_ctrl_reg[`ASTRF_RX_NINE] &
                     ~rx_char[8]);
    wire rx_done = rx_run & tick16 & (rx_state_reg == RX_STOP) &
                   (rx_cnt_reg == `ASTRF_OS_DECIDE);
    wire push = rx_done & rx_keep & (fifo_cnt_reg != 2'd2);

    // pin synchroniser
    always @(posedge clk) begin
        if (!nrst) begin
            rx_sync1_reg <= 1'b1;
            rx_sync2_reg <= 1'b1;
        end else begin
            rx_sync1_reg <= receive_pin;
            rx_sync2_reg <= rx_sync1_reg;
        end
    end

    // data recovery at sixteen samples per bit
    always @(posedge clk) begin
        if (!nrst || !rx_run) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg <= 4'h0;
            rx_smp_reg <= 2'b11;
            rx_shift_reg <= 9'h000;
            rx_nbit_reg <= 4'h0;
        end else if (tick16) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == `ASTRF_OS_SMP_A) begin
                rx_smp_reg[0] <= rx_sync2_reg;
            end
            if (rx_cnt_reg == `ASTRF_OS_SMP_B) begin
                rx_smp_reg[1] <= rx_sync2_reg;
            end
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_cnt_reg <= 4'h0;
                    if (!rx_sync2_reg) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_reg == `ASTRF_OS_DECIDE && rx_bit) begin
                        rx_state_reg <= RX_IDLE;
                    end else if (rx_cnt_reg == `ASTRF_OS_LAST) begin
                        rx_state_reg <= RX_DATA;
                        rx_nbit_reg <= 4'hF; // counts from -1
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_reg == `ASTRF_OS_DECIDE) begin
                        rx_shift_reg <= {rx_bit, rx_shift_reg[8:1]};
                    end
                    if (rx_cnt_reg == `ASTRF_OS_LAST) begin
                        rx_nbit_reg <= rx_nbit_reg + 4'h1;
                        if (rx_nbit_reg == {3'b011, rx_ctrl_reg[`ASTRF_RX_NINE]}) begin
                            rx_state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_reg == `ASTRF_OS_DECIDE) begin
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // two-entry receive buffer with overrun capture
    always @(posedge clk) begin
        if (!nrst || !port_on) begin
            fifo_wp_reg <= 1'b0;
            fifo_rp_reg <= 1'b0;
            fifo_cnt_reg <= 2'd0;
            fifo_mem[0] <= 10'h000;
            fifo_mem[1] <= 10'h000;
            oerr_reg <= 1'b0;
        end else begin
            if (push) begin
                fifo_mem[fifo_wp_reg] <= {~rx_bit, rx_char};
                fifo_wp_reg <= ~fifo_wp_reg;
            end
            if (pop) begin
                fifo_rp_reg <= ~fifo_rp_reg;
            end
            if (push && !pop) begin
                fifo_cnt_reg <= fifo_cnt_reg + 2'd1;
            end else if (pop && !push) begin
                fifo_cnt_reg <= fifo_cnt_reg - 2'd1;
            end
            if (!rx_on) begin
                oerr_reg <= 1'b0;
            end else if (rx_done && rx_keep && fifo_cnt_reg == 2'd2) begin
                oerr_reg <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/astrf_regs.vh */
// register map, field positions and reset values of the serial front
`ifndef ASTRF_REGS_VH
`define ASTRF_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ASTRF_OFF_TX_CTRL 8'h00
`define ASTRF_OFF_RX_CTRL 8'h04
`define ASTRF_OFF_BAUD_CTRL 8'h08
`define ASTRF_OFF_DIV_LO 8'h0C
`define ASTRF_OFF_DIV_HI 8'h10
`define ASTRF_OFF_TX_BUF 8'h14
`define ASTRF_OFF_RX_DATA 8'h18
`define ASTRF_OFF_INT_CTRL 8'h1C
// ----------------------------------------
// transmit_status_control fields
// ----------------------------------------
`define ASTRF_TX_CLK_SRC 7
`define ASTRF_TX_NINE 6
`define ASTRF_TX_EN 5
`define ASTRF_TX_SYNC 4
`define ASTRF_TX_BREAK 3
`define ASTRF_TX_HISPEED 2
`define ASTRF_TX_SR_EMPTY 1
`define ASTRF_TX_NINTH 0
// ----------------------------------------
// receive_status_control fields
// ----------------------------------------
`define ASTRF_RX_PORT_EN 7
`define ASTRF_RX_NINE 6
`define ASTRF_RX_SINGLE 5
`define ASTRF_RX_CONT_EN 4
`define ASTRF_RX_ADDR_DET 3
`define ASTRF_RX_FRAME_ERR 2
`define ASTRF_RX_OVERRUN 1
`define ASTRF_RX_NINTH 0
// ----------------------------------------
// baud_control and interrupt control fields
// ----------------------------------------
`define ASTRF_BAUD_RX_IDLE 6
`define ASTRF_BAUD_WIDE 3
`define ASTRF_INT_TX_EN 0
`define ASTRF_INT_RX_EN 1
`define ASTRF_INT_PERIPH_EN 2
`define ASTRF_INT_GLOBAL_EN 3
`define ASTRF_INT_TX_FLAG 4
`define ASTRF_INT_RX_FLAG 5
// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define ASTRF_RST_BYTE 8'h00
`define ASTRF_RST_DIV 16'h0000
`define ASTRF_OS_LAST 4'hF
`define ASTRF_OS_SMP_A 4'h7
`define ASTRF_OS_SMP_B 4'h8
`define ASTRF_OS_DECIDE 4'h9
`define ASTRF_BITS_8 4'hA
`define ASTRF_BITS_9 4'hB
`define ASTRF_RESP_OKAY 2'b00
`define ASTRF_RESP_SLVERR 2'b10
`endif

/* File: verilog/astrf_baud_gen.v */
// baud divider producing the sixteen-times oversample enable pulse
`timescale 1ns/100ps
`default_nettype none
module astrf_baud_gen (
    // clock and reset
    input wire clk,
    input wire nrst,
    // control
    input wire enable,
    input wire wide,
    input wire [15:0] divisor,
    // oversample enable
    output reg tick16
);
    reg [15:0] cnt_reg;
    wire [15:0] reload = wide ? divisor : {8'h00, divisor[7:0]};

    // count down, one pulse per reload+1 clocks (divisor low byte only unless wide)
    always @(posedge clk) begin
        if (!nrst || !enable) begin
            cnt_reg <= 16'h0000;
            tick16 <= 1'b0;
        end else if (cnt_reg == 16'h0000) begin
            cnt_reg <= reload;
            tick16 <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg - 16'h0001;
            tick16 <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb/astrf_node.sv */
// remote serial node model: captures device frames and sends frames back
`timescale 1ns/100ps
`default_nettype none
module astrf_node #(
    parameter int BIT_CLKS = 32
) (
    // clock
    input wire logic clk,
    // serial lines
    input wire logic line_in,
    output logic line_out,
    // expected frame length of captured frames
    input wire logic nine
);
    logic [8:0] got_data;
    logic got_stop;
    int got_count;
    logic [8:0] sh;

    // capture: start on low sample, recheck at centre, then one sample per bit
    initial begin
        got_count = 0;
        got_data = 9'h000;
        got_stop = 1'b0;
        line_out = 1'b1;
        forever begin
            @(posedge clk);
            if (line_in === 1'b0) begin
                sh = 9'h000;
                repeat (BIT_CLKS / 2) @(posedge clk);
                if (line_in === 1'b0) begin
                    for (int i = 0; i < (nine ? 9 : 8); i++) begin
                        repeat (BIT_CLKS) @(posedge clk);
                        sh[i] = line_in;
                    end
                    repeat (BIT_CLKS) @(posedge clk);
                    got_stop = line_in;
                    got_data = sh;
                    got_count++;
                end
            end
        end
    end

    // send one frame: space start, data lsb first, one mark stop
    task automatic send(input logic [8:0] d, input logic nb);
        line_out <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (int i = 0; i < (nb ? 9 : 8); i++) begin
            line_out <= d[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/astrf_uart_props.sv */
// port-level concurrent checks of the serial front
`timescale 1ns/100ps
`default_nettype none
`include "astrf_regs.vh"
module astrf_uart_props (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins and interrupt
    input wire logic transmit_pin_out,
    input wire logic transmit_pin_oe,
    input wire logic serial_irq
);
    logic bad_ar;

    // read address outside the map or not word aligned
    assign bad_ar = s_axi_araddr > 8'h1C || s_axi_araddr[1:0] != 2'b00;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_reset_idle: assert property (disable iff (1'b0) !nrst |=>
        !s_axi_bvalid && !s_axi_rvalid && transmit_pin_out && !transmit_pin_oe && !serial_irq)
        else $error("outputs not idle after reset");
    a_start_len: assert property ($fell(transmit_pin_out) |-> !transmit_pin_out [*8])
        else $error("start bit too short");
    a_b_stable: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_stable: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_slverr: assert property (s_axi_arvalid && s_axi_arready && bad_ar |=>
        s_axi_rresp == `ASTRF_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_read_okay: assert property (s_axi_arvalid && s_axi_arready && !bad_ar |=>
        s_axi_rresp == `ASTRF_RESP_OKAY)
        else $error("mapped read refused");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule

bind astrf_uart astrf_uart_props u_astrf_uart_props (.clk(clk), .nrst(nrst),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .transmit_pin_out(transmit_pin_out), .transmit_pin_oe(transmit_pin_oe),
    .serial_irq(serial_irq));
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the serial front
`timescale 1ns/100ps
`default_nettype none
`include "astrf_regs.vh"
module tb;
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, rx_line, nine;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    wire awready, wready, bvalid, arready, rvalid, tx_out, tx_oe, irq, node_in;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int miscompares, comparisons;
    integer seed;

    astrf_uart u_astrf_uart (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .receive_pin(rx_line), .transmit_pin_out(tx_out),
        .transmit_pin_oe(tx_oe), .serial_irq(irq));
    astrf_node #(.BIT_CLKS(32)) u_astrf_node (.clk(clk), .line_in(node_in),
        .line_out(rx_line), .nine(nine));
    // a released transmit line is pulled to mark
    assign node_in = tx_oe ? tx_out : 1'b1;

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [1:0] exp_resp(input logic [7:0] a);
        return (a > 8'h1C || a[1:0] != 2'b00) ? `ASTRF_RESP_SLVERR : `ASTRF_RESP_OKAY;
    endfunction

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk2(input logic [1:0] got, input logic [1:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s response %b expected %b", $time, msg, got, exp);
        end
    endtask

    // bus write, response compared against the map
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge clk);
            if (!aw_d && awready) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_d && wready) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end
        repeat ($unsigned($random(seed)) % 3) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        chk2(bresp, exp_resp(a), "write");
        bready <= 1'b0;
        @(posedge clk);
    endtask

    // bus read, masked data and response compared
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string msg);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        repeat ($unsigned($random(seed)) % 3) @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        chk32(rdata & m, e, msg);
        chk2(rresp, exp_resp(a), msg);
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        wrap_up;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n;
        logic nb;
        logic [8:0] d;
        logic [7:0] q [3];
        seed = 32'h776ED4E6;
        miscompares = 0;
        comparisons = 0;
        {nrst, awvalid, wvalid, bready, arvalid, rready, nine} = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(`ASTRF_OFF_TX_CTRL, 32'hFFFFFFFF, 32'h00000002, "tx ctrl reset");
        rd(`ASTRF_OFF_INT_CTRL, 32'hFFFFFFFF, 32'h00000000, "int ctrl reset");
        wr(`ASTRF_OFF_DIV_LO, 8'h01);
        wr(`ASTRF_OFF_RX_CTRL, 8'h90);
        wr(`ASTRF_OFF_TX_CTRL, 8'h20);
        rd(`ASTRF_OFF_TX_CTRL, 32'hFFFFFFFF, 32'h00000022, "read-only flag");
        rd(`ASTRF_OFF_INT_CTRL, 32'h10, 32'h10, "tx flag on enable");
        wr(`ASTRF_OFF_INT_CTRL, 8'h0D);
        chk32({31'h0, irq}, 32'h1, "irq on enable");
        wr(`ASTRF_OFF_INT_CTRL, 8'h0C);
        chk32({31'h0, irq}, 32'h0, "irq masked");
        // transmit: two 8-bit then three 9-bit characters
        for (int i = 0; i < 5; i++) begin
            nb = (i >= 2);
            nine <= nb;
            d = 9'($random(seed));
            d[8] = nb & i[0];
            wr(`ASTRF_OFF_TX_CTRL, {1'b0, nb, 1'b1, 4'h0, d[8]});
            n = u_astrf_node.got_count;
            wr(`ASTRF_OFF_TX_BUF, d[7:0]);
            rd(`ASTRF_OFF_TX_CTRL, 32'h2, 32'h0, "shifter busy");
            while (u_astrf_node.got_count <= n) @(posedge clk);
            chk32({23'h0, u_astrf_node.got_data}, {23'h0, d}, "tx frame");
            chk32({31'h0, u_astrf_node.got_stop}, 32'h1, "tx stop");
            repeat (32) @(posedge clk);
            rd(`ASTRF_OFF_TX_CTRL, 32'h2, 32'h2, "shifter empty");
        end
        // receive three characters with no reads between
        for (int i = 0; i < 3; i++) begin
            q[i] = 8'($random(seed));
            u_astrf_node.send({1'b0, q[i]}, 1'b0);
        end
        repeat (64) @(posedge clk);
        rd(`ASTRF_OFF_INT_CTRL, 32'h20, 32'h20, "rx flag");
        rd(`ASTRF_OFF_RX_CTRL, 32'h2, 32'h2, "overrun");
        rd(`ASTRF_OFF_RX_DATA, 32'hFFFFFFFF, {24'h0, q[0]}, "rx first");
        rd(`ASTRF_OFF_RX_DATA, 32'hFFFFFFFF, {24'h0, q[1]}, "rx second");
        rd(`ASTRF_OFF_INT_CTRL, 32'h20, 32'h00, "rx drained");
        // receiver off ignores the line
        wr(`ASTRF_OFF_RX_CTRL, 8'h80);
        u_astrf_node.send(9'h0A5, 1'b0);
        repeat (64) @(posedge clk);
        rd(`ASTRF_OFF_INT_CTRL, 32'h20, 32'h00, "rx off");
        rd(`ASTRF_OFF_RX_CTRL, 32'h2, 32'h0, "overrun cleared");
        // nine-bit reception
        wr(`ASTRF_OFF_RX_CTRL, 8'hD0);
        d = 9'($random(seed));
        d[8] = 1'b1;
        u_astrf_node.send(d, 1'b1);
        repeat (64) @(posedge clk);
        rd(`ASTRF_OFF_RX_CTRL, 32'h1, 32'h1, "rx ninth");
        rd(`ASTRF_OFF_RX_DATA, 32'hFFFFFFFF, {24'h0, d[7:0]}, "rx nine data");
        // register map corners
        rd(`ASTRF_OFF_DIV_LO, 32'hFFFFFFFF, 32'h00000001, "divider low");
        rd(`ASTRF_OFF_TX_BUF, 32'hFFFFFFFF, 32'h00000000, "tx buffer write only");
        rd(8'h20, 32'hFFFFFFFF, 32'h00000000, "unmapped read");
        rd(8'h02, 32'hFFFFFFFF, 32'h00000000, "unaligned read");
        wr(8'h24, 8'h5A);
        wrap_up;
    end
endmodule
`default_nettype wire
